// ===== ccp_clock_tree.v
// codec clock tree: root select, pll model, dividers, clock outputs, apb
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "ccp_defs.vh"

// Operation
// - root clock picked from master pin, bit pin, general pin one or pll
// - dac modulator tick is root over pre times mod; rate further by osr
// - dac oversample ratio is ten bits split over two registers
// - adc modulator tick is root over pre times mod; rate by 8-bit osr
// - dac dividers only tick while their top enable bit is set
// - adc dividers only tick while their top enable bit is set
// - channel power-down runs a shut-down count paced by its dividers
// - with both adc dividers off adc ticks come from dac dividers
// - bit pin driven with source over 1 to 128 when enabled
// - bit divider source picks dac or adc processing or modulator tick
// - general clock out on four pins, source over 1 to 128
// - general divider source chosen by a three-bit field
// - pll switched by top bit of its first control register
// - pll output equals input times r times j.d over p
// - p and r share one register, j in the next
// - pll factors reset to r 1, j 4, d 0, p 1
// - fraction d is fourteen bits split over two registers
// - new fraction takes effect only when the lower half is written
module ccp_clock_tree #(
  parameter SHUTDOWN_TICKS = `CCP_SHUTDOWN_TICKS
) (
  // clock and reset
  input wire sys_clk_in,
  input wire rst_n_in,
  // apb slave
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  // clock input pins
  input wire mclk_in,
  input wire bclk_in,
  input wire gp1_in,
  // bit clock pin drive
  output reg bclk_out,
  output reg bclk_oe_out,
  // general clock pins drive
  output reg gp1_out,
  output reg gp1_oe_out,
  output reg gp2_out,
  output reg gp2_oe_out,
  output reg serial_data_out_pin_out,
  output reg serial_data_out_pin_oe_out,
  output reg miso_out,
  output reg miso_oe_out
);

  // register storage
  reg [7:0] root_sel;
  reg [7:0] pll_epr;
  reg [7:0] pll_j;
  reg [7:0] pll_dhi_shadow;
  reg [13:0] pll_d_active;
  reg [7:0] pll_dlo;
  reg [7:0] dac_pre;
  reg [7:0] dac_mod;
  reg [7:0] dac_oversample_ratio_hi;
  reg [7:0] dac_oversample_ratio_lo;
  reg [7:0] adc_pre;
  reg [7:0] adc_mod;
  reg [7:0] adc_oversample_ratio;
  reg [7:0] gclk_sel;
  reg [7:0] gclk_div;
  reg [7:0] bclk_ctrl;
  reg [7:0] bclk_sel;
  reg [7:0] bclk_div;
  reg [7:0] gclk_route;
  reg [7:0] chan_power;

  // divider counters and other state
  reg [9:0] dac_pre_cnt;
  reg [9:0] dac_mod_cnt;
  reg [9:0] dac_oversample_ratio_cnt;
  reg [9:0] adc_pre_cnt;
  reg [9:0] adc_mod_cnt;
  reg [9:0] adc_oversample_ratio_cnt;
  reg [9:0] bclk_cnt;
  reg [9:0] gclk_cnt;
  reg mclk_prev;
  reg bclk_prev;
  reg gp1_prev;
  reg pll_tick;
  reg [27:0] pll_credit;
  reg [7:0] dac_l_sd;
  reg [7:0] dac_r_sd;
  reg [7:0] adc_sd;

  // ratio of a 7-bit field, zero meaning 128
  function [10:0] ratio7;
    input [6:0] f;
    begin
      if (f == 7'h00) begin
        ratio7 = 11'h080;
      end else begin
        ratio7 = {4'h0, f};
      end
    end
  endfunction

  // one divider step: {terminal tick, next count}
  function [10:0] div_step;
    input [9:0] cnt;
    input [10:0] ratio;
    input run;
    begin
      if (!run) begin
        div_step = {1'b0, cnt};
      end else if ({1'b0, cnt} == ratio - 11'h001) begin
        div_step = {1'b1, 10'h000};
      end else begin
        div_step = {1'b0, cnt + 10'h001};
      end
    end
  endfunction

  // one shut-down count step, paced by the channel modulator tick
  function [7:0] sd_step;
    input [7:0] cnt;
    input pwr_on;
    input pwr_was;
    input tick;
    begin
      // the power-down write wins over the old power bit
      if (pwr_was) begin
        sd_step = SHUTDOWN_TICKS[7:0];
      end else if (pwr_on) begin
        sd_step = 8'h00;
      end else if (tick && cnt != 8'h00) begin
        sd_step = cnt - 8'h01;
      end else begin
        sd_step = cnt;
      end
    end
  endfunction

  // source edges: pins are synchronous, rising edge is one source tick
  wire mclk_tick = mclk_in & ~mclk_prev;
  wire bclk_tick = bclk_in & ~bclk_prev;
  wire gp1_tick = gp1_in & ~gp1_prev;

  // pll input and root selection
  reg pll_in_tick;
  reg root_tick;
  always @* begin
    case (root_sel[3:2])
      `CCP_SRC_BCLK: pll_in_tick = bclk_tick;
      `CCP_SRC_GP1: pll_in_tick = gp1_tick;
      default: pll_in_tick = mclk_tick;
    endcase
    case (root_sel[1:0])
      `CCP_SRC_MCLK: root_tick = mclk_tick;
      `CCP_SRC_BCLK: root_tick = bclk_tick;
      `CCP_SRC_GP1: root_tick = gp1_tick;
      `CCP_SRC_PLL: root_tick = pll_tick;
      default: root_tick = 1'b0;
    endcase
  end

  // pll factors decoded from their fields
  wire pll_on = pll_epr[`CCP_EN_BIT];
  wire [3:0] p_fact = (pll_epr[6:4] == 3'h0) ? 4'h8 : {1'b0, pll_epr[6:4]};
  wire [4:0] r_fact = (pll_epr[3:0] == 4'h0) ? 5'h10 : {1'b0, pll_epr[3:0]};
  wire [19:0] jd_fact = pll_j[5:0] * `CCP_PLL_FRAC_SCALE
    + {6'h00, pll_d_active};
  wire [24:0] pll_inc = jd_fact * r_fact;
  wire [23:0] pll_thr = `CCP_PLL_FRAC_SCALE * p_fact;

  // dac chain
  wire en_dac_pre = dac_pre[`CCP_EN_BIT];
  wire en_dac_mod = dac_mod[`CCP_EN_BIT];
  wire [10:0] dac_pre_s = div_step(dac_pre_cnt, ratio7(dac_pre[6:0]),
    en_dac_pre & root_tick);
  wire [10:0] dac_mod_s = div_step(dac_mod_cnt, ratio7(dac_mod[6:0]),
    en_dac_mod & dac_pre_s[10]);
  wire [9:0] dac_oversample_ratio_val = {dac_oversample_ratio_hi[1:0], dac_oversample_ratio_lo};
  wire [10:0] dac_oversample_ratio_ratio = (dac_oversample_ratio_val == 10'h000) ? 11'h400
    : {1'b0, dac_oversample_ratio_val};
  wire [10:0] dac_oversample_ratio_s = div_step(dac_oversample_ratio_cnt, dac_oversample_ratio_ratio, dac_mod_s[10]);

  // adc chain, falling back to dac ticks with both dividers off
  wire en_adc_pre = adc_pre[`CCP_EN_BIT];
  wire en_adc_mod = adc_mod[`CCP_EN_BIT];
  wire adc_from_dac = ~en_adc_pre & ~en_adc_mod;
  wire [10:0] adc_pre_s = div_step(adc_pre_cnt, ratio7(adc_pre[6:0]),
    en_adc_pre & root_tick);
  wire [10:0] adc_mod_s = div_step(adc_mod_cnt, ratio7(adc_mod[6:0]),
    en_adc_mod & adc_pre_s[10]);
  wire adc_proc_tick = adc_from_dac ? dac_pre_s[10] : adc_pre_s[10];
  wire adc_mod_tick = adc_from_dac ? dac_mod_s[10] : adc_mod_s[10];
  wire [10:0] adc_oversample_ratio_ratio = (adc_oversample_ratio == 8'h00) ? 11'h100 : {3'h0, adc_oversample_ratio};
  wire [10:0] adc_oversample_ratio_s = div_step(adc_oversample_ratio_cnt, adc_oversample_ratio_ratio, adc_mod_tick);

  // output divider sources
  reg bclk_src;
  reg gclk_src;
  always @* begin
    case (bclk_sel[1:0])
      2'h0: bclk_src = dac_pre_s[10];
      2'h1: bclk_src = dac_mod_s[10];
      2'h2: bclk_src = adc_proc_tick;
      2'h3: bclk_src = adc_mod_tick;
      default: bclk_src = 1'b0;
    endcase
    case (gclk_sel[2:0])
      3'h0: gclk_src = root_tick;
      3'h1: gclk_src = pll_tick;
      3'h2: gclk_src = dac_pre_s[10];
      3'h3: gclk_src = dac_mod_s[10];
      3'h4: gclk_src = adc_proc_tick;
      3'h5: gclk_src = adc_mod_tick;
      3'h6: gclk_src = dac_oversample_ratio_s[10];
      3'h7: gclk_src = adc_oversample_ratio_s[10];
      default: gclk_src = 1'b0;
    endcase
  end
  wire [10:0] bclk_ratio = ratio7(bclk_div[6:0]);
  wire [10:0] gclk_ratio = ratio7(gclk_div[6:0]);
  wire [10:0] bclk_s = div_step(bclk_cnt, bclk_ratio, bclk_src);
  wire [10:0] gclk_s = div_step(gclk_cnt, gclk_ratio, gclk_src);
  wire next_bclk = (bclk_ratio == 11'h001) ? bclk_src
    : ({1'b0, bclk_s[9:0]} < {1'b0, bclk_ratio[10:1]});
  wire next_gclk = (gclk_ratio == 11'h001) ? gclk_src
    : ({1'b0, gclk_s[9:0]} < {1'b0, gclk_ratio[10:1]});

  // channel power flags, held high until the shut-down count ends
  wire flag_dac_l = chan_power[`CCP_PWR_DAC_L_BIT] | (dac_l_sd != 8'h00);
  wire flag_dac_r = chan_power[`CCP_PWR_DAC_R_BIT] | (dac_r_sd != 8'h00);
  wire flag_adc = chan_power[`CCP_PWR_ADC_BIT] | (adc_sd != 8'h00);

  // apb decode
  wire [5:0] idx = paddr_in[7:2];
  wire setup = psel_in & ~penable_in;
  wire wr_go = psel_in & penable_in & pready_out & pwrite_in & ~pslverr_out;
  reg hit;
  reg [7:0] rd_val;
  always @* begin
    hit = 1'b1;
    rd_val = 8'h00;
    case (idx)
      `CCP_IDX_ROOT_SEL: rd_val = root_sel;
      `CCP_IDX_PLL_EPR: rd_val = pll_epr;
      `CCP_IDX_PLL_J: rd_val = pll_j;
      `CCP_IDX_PLL_DHI: rd_val = pll_dhi_shadow;
      `CCP_IDX_PLL_DLO: rd_val = pll_dlo;
      `CCP_IDX_DAC_PRE: rd_val = dac_pre;
      `CCP_IDX_DAC_MOD: rd_val = dac_mod;
      `CCP_IDX_DAC_OVERSAMPLE_RATIO_HI: rd_val = dac_oversample_ratio_hi;
      `CCP_IDX_DAC_OVERSAMPLE_RATIO_LO: rd_val = dac_oversample_ratio_lo;
      `CCP_IDX_ADC_PRE: rd_val = adc_pre;
      `CCP_IDX_ADC_MOD: rd_val = adc_mod;
      `CCP_IDX_ADC_OVERSAMPLE_RATIO: rd_val = adc_oversample_ratio;
      `CCP_IDX_GCLK_SEL: rd_val = gclk_sel;
      `CCP_IDX_GCLK_DIV: rd_val = gclk_div;
      `CCP_IDX_BCLK_CTRL: rd_val = bclk_ctrl;
      `CCP_IDX_BCLK_SEL: rd_val = bclk_sel;
      `CCP_IDX_BCLK_DIV: rd_val = bclk_div;
      `CCP_IDX_GCLK_ROUTE: rd_val = gclk_route;
      `CCP_IDX_CHAN_POWER: rd_val = chan_power;
      `CCP_IDX_ADC_FLAGS: rd_val = {1'b0, flag_adc, 6'h00};
      `CCP_IDX_DAC_FLAGS: rd_val = {flag_dac_l, 3'h0, flag_dac_r, 3'h0};
      default: hit = 1'b0;
    endcase
    if (paddr_in[1:0] != 2'h0) begin
      hit = 1'b0;
    end
  end

  // apb answer: ready in the first access cycle
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h00000000;
    end else if (setup) begin
      pready_out <= 1'b1;
      pslverr_out <= ~hit;
      prdata_out <= (hit && !pwrite_in) ? {24'h000000, rd_val}
        : 32'h00000000;
    end else begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end
  end

  // register writes
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      root_sel <= `CCP_RST_ROOT_SEL;
      pll_epr <= `CCP_RST_PLL_EPR;
      pll_j <= `CCP_RST_PLL_J;
      pll_dhi_shadow <= `CCP_RST_PLL_DHI;
      pll_dlo <= `CCP_RST_PLL_DLO;
      pll_d_active <= 14'h0000;
      dac_pre <= `CCP_RST_DIV;
      dac_mod <= `CCP_RST_DIV;
      dac_oversample_ratio_hi <= `CCP_RST_DAC_OVERSAMPLE_RATIO_HI;
      dac_oversample_ratio_lo <= `CCP_RST_DAC_OVERSAMPLE_RATIO_LO;
      adc_pre <= `CCP_RST_DIV;
      adc_mod <= `CCP_RST_DIV;
      adc_oversample_ratio <= `CCP_RST_ADC_OVERSAMPLE_RATIO;
      gclk_sel <= `CCP_RST_ZERO;
      gclk_div <= `CCP_RST_DIV;
      bclk_ctrl <= `CCP_RST_ZERO;
      bclk_sel <= `CCP_RST_ZERO;
      bclk_div <= `CCP_RST_DIV;
      gclk_route <= `CCP_RST_ZERO;
      chan_power <= `CCP_RST_ZERO;
    end else if (wr_go) begin
      case (idx)
        `CCP_IDX_ROOT_SEL: root_sel <= {4'h0, pwdata_in[3:0]};
        `CCP_IDX_PLL_EPR: pll_epr <= pwdata_in[7:0];
        `CCP_IDX_PLL_J: pll_j <= {2'h0, pwdata_in[5:0]};
        `CCP_IDX_PLL_DHI: pll_dhi_shadow <= {2'h0, pwdata_in[5:0]};
        `CCP_IDX_PLL_DLO: begin
          pll_dlo <= pwdata_in[7:0];
          pll_d_active <= {pll_dhi_shadow[5:0],
            pwdata_in[7:0]};
        end
        `CCP_IDX_DAC_PRE: dac_pre <= pwdata_in[7:0];
        `CCP_IDX_DAC_MOD: dac_mod <= pwdata_in[7:0];
        `CCP_IDX_DAC_OVERSAMPLE_RATIO_HI: dac_oversample_ratio_hi <= {6'h00, pwdata_in[1:0]};
        `CCP_IDX_DAC_OVERSAMPLE_RATIO_LO: dac_oversample_ratio_lo <= pwdata_in[7:0];
        `CCP_IDX_ADC_PRE: adc_pre <= pwdata_in[7:0];
        `CCP_IDX_ADC_MOD: adc_mod <= pwdata_in[7:0];
        `CCP_IDX_ADC_OVERSAMPLE_RATIO: adc_oversample_ratio <= pwdata_in[7:0];
        `CCP_IDX_GCLK_SEL: gclk_sel <= {5'h00, pwdata_in[2:0]};
        `CCP_IDX_GCLK_DIV: gclk_div <= {1'b0, pwdata_in[6:0]};
        `CCP_IDX_BCLK_CTRL: bclk_ctrl <= {4'h0, pwdata_in[3], 3'h0};
        `CCP_IDX_BCLK_SEL: bclk_sel <= {6'h00, pwdata_in[1:0]};
        `CCP_IDX_BCLK_DIV: bclk_div <= {1'b0, pwdata_in[6:0]};
        `CCP_IDX_GCLK_ROUTE: gclk_route <= {4'h0, pwdata_in[3:0]};
        `CCP_IDX_CHAN_POWER: chan_power <= {pwdata_in[7:5], 5'h00};
        default: root_sel <= root_sel;
      endcase
    end
  end

  // pll model: credit grows per input tick, one output tick per threshold
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pll_credit <= 28'h0000000;
      pll_tick <= 1'b0;
    end else if (!pll_on) begin
      pll_credit <= 28'h0000000;
      pll_tick <= 1'b0;
    end else begin
      pll_tick <= (pll_credit >= {4'h0, pll_thr});
      pll_credit <= pll_credit
        + ((pll_in_tick && !pll_credit[27]) ? {3'h0, pll_inc} : 28'h0000000)
        - ((pll_credit >= {4'h0, pll_thr}) ? {4'h0, pll_thr} : 28'h0000000);
    end
  end

  // divider counters, edge history and shut-down counts
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mclk_prev <= 1'b0;
      bclk_prev <= 1'b0;
      gp1_prev <= 1'b0;
      dac_pre_cnt <= 10'h000;
      dac_mod_cnt <= 10'h000;
      dac_oversample_ratio_cnt <= 10'h000;
      adc_pre_cnt <= 10'h000;
      adc_mod_cnt <= 10'h000;
      adc_oversample_ratio_cnt <= 10'h000;
      bclk_cnt <= 10'h000;
      gclk_cnt <= 10'h000;
      dac_l_sd <= 8'h00;
      dac_r_sd <= 8'h00;
      adc_sd <= 8'h00;
    end else begin
      mclk_prev <= mclk_in;
      bclk_prev <= bclk_in;
      gp1_prev <= gp1_in;
      dac_pre_cnt <= dac_pre_s[9:0];
      dac_mod_cnt <= dac_mod_s[9:0];
      dac_oversample_ratio_cnt <= dac_oversample_ratio_s[9:0];
      adc_pre_cnt <= adc_pre_s[9:0];
      adc_mod_cnt <= adc_mod_s[9:0];
      adc_oversample_ratio_cnt <= adc_oversample_ratio_s[9:0];
      bclk_cnt <= bclk_s[9:0];
      gclk_cnt <= gclk_s[9:0];
      dac_l_sd <= sd_step(dac_l_sd, chan_power[`CCP_PWR_DAC_L_BIT],
        wr_go && idx == `CCP_IDX_CHAN_POWER && !pwdata_in[7]
          && chan_power[`CCP_PWR_DAC_L_BIT],
        dac_mod_s[10]);
      dac_r_sd <= sd_step(dac_r_sd, chan_power[`CCP_PWR_DAC_R_BIT],
        wr_go && idx == `CCP_IDX_CHAN_POWER && !pwdata_in[6]
          && chan_power[`CCP_PWR_DAC_R_BIT],
        dac_mod_s[10]);
      adc_sd <= sd_step(adc_sd, chan_power[`CCP_PWR_ADC_BIT],
        wr_go && idx == `CCP_IDX_CHAN_POWER && !pwdata_in[5]
          && chan_power[`CCP_PWR_ADC_BIT],
        adc_mod_tick);
    end
  end

  // pin drive, all from flops
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bclk_out <= 1'b0;
      bclk_oe_out <= 1'b0;
      gp1_out <= 1'b0;
      gp1_oe_out <= 1'b0;
      gp2_out <= 1'b0;
      gp2_oe_out <= 1'b0;
      serial_data_out_pin_out <= 1'b0;
      serial_data_out_pin_oe_out <= 1'b0;
      miso_out <= 1'b0;
      miso_oe_out <= 1'b0;
    end else begin
      bclk_oe_out <= bclk_ctrl[`CCP_BCLK_OE_BIT];
      bclk_out <= bclk_ctrl[`CCP_BCLK_OE_BIT] & next_bclk;
      gp1_oe_out <= gclk_route[0];
      gp1_out <= gclk_route[0] & next_gclk;
      gp2_oe_out <= gclk_route[1];
      gp2_out <= gclk_route[1] & next_gclk;
      serial_data_out_pin_oe_out <= gclk_route[2];
      serial_data_out_pin_out <= gclk_route[2] & next_gclk;
      miso_oe_out <= gclk_route[3];
      miso_out <= gclk_route[3] & next_gclk;
    end
  end

endmodule
`default_nettype wire

// ===== ccp_clock_tree_properties.sv
// concurrent checks on the codec clock tree apb port and pin enables
`timescale 1ns/1ns
`default_nettype none
`include "ccp_defs.vh"
module ccp_properties (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // apb
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // pin enables
  input wire logic bclk_oe_out,
  input wire logic gp1_oe_out,
  input wire logic gp2_oe_out,
  input wire logic serial_data_out_pin_oe_out,
  input wire logic miso_oe_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic setup;
  logic wr_done;
  // setup phase and completed write
  assign setup = psel_in && !penable_in;
  assign wr_done = psel_in && penable_in && pwrite_in && pready_out;
  ready_after_setup_a:
    assert property (setup |=> pready_out) else $error("ready missing");
  ready_single_a:
    assert property (pready_out |=> !pready_out) else $error("ready held");
  ready_has_cause_a:
    assert property (pready_out |-> $past(setup)) else $error("stray ready");
  error_data_zero_a:
    assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
      else $error("bad error response");
  misalign_error_a:
    assert property (setup && paddr_in[1:0] != 2'h0 |=> pslverr_out)
      else $error("misaligned access accepted");
  unmapped_error_a:
    assert property (setup && paddr_in[7:2] == 6'h3F |=> pslverr_out)
      else $error("unmapped access accepted");
  fraction_mapped_a:
    assert property (setup && paddr_in == {`CCP_IDX_PLL_DLO, 2'h0}
      |=> pready_out && !pslverr_out) else $error("fraction low refused");
  upper_data_zero_a:
    assert property (pready_out |-> prdata_out[31:8] == 24'h0)
      else $error("read data upper bits set");
  enables_by_write_a:
    assert property ($changed({bclk_oe_out, gp1_oe_out, gp2_oe_out,
      serial_data_out_pin_oe_out, miso_oe_out}) |-> $past(wr_done) || $past(wr_done, 2)
      || $past(wr_done, 3)) else $error("pin enable moved without write");
endmodule
`default_nettype wire

// ===== ccp_defs.vh
// register indices, field positions, reset values and counts for ccp
`ifndef CCP_DEFS_VH
`define CCP_DEFS_VH

// register indices (byte address is four times the index)
`define CCP_IDX_ROOT_SEL 6'h04
`define CCP_IDX_PLL_EPR 6'h05
`define CCP_IDX_PLL_J 6'h06
`define CCP_IDX_PLL_DHI 6'h07
`define CCP_IDX_PLL_DLO 6'h08
`define CCP_IDX_DAC_PRE 6'h0B
`define CCP_IDX_DAC_MOD 6'h0C
`define CCP_IDX_DAC_OVERSAMPLE_RATIO_HI 6'h0D
`define CCP_IDX_DAC_OVERSAMPLE_RATIO_LO 6'h0E
`define CCP_IDX_ADC_PRE 6'h12
`define CCP_IDX_ADC_MOD 6'h13
`define CCP_IDX_ADC_OVERSAMPLE_RATIO 6'h14
`define CCP_IDX_GCLK_SEL 6'h19
`define CCP_IDX_GCLK_DIV 6'h1A
`define CCP_IDX_BCLK_CTRL 6'h1B
`define CCP_IDX_BCLK_SEL 6'h1D
`define CCP_IDX_BCLK_DIV 6'h1E
`define CCP_IDX_GCLK_ROUTE 6'h20
`define CCP_IDX_CHAN_POWER 6'h21
`define CCP_IDX_ADC_FLAGS 6'h24
`define CCP_IDX_DAC_FLAGS 6'h25

// field positions
`define CCP_EN_BIT 7
`define CCP_BCLK_OE_BIT 3
`define CCP_DAC_L_FLAG_BIT 7
`define CCP_DAC_R_FLAG_BIT 3
`define CCP_ADC_FLAG_BIT 6
`define CCP_PWR_DAC_L_BIT 7
`define CCP_PWR_DAC_R_BIT 6
`define CCP_PWR_ADC_BIT 5

// reset values
`define CCP_RST_ROOT_SEL 8'h00
`define CCP_RST_PLL_EPR 8'h11
`define CCP_RST_PLL_J 8'h04
`define CCP_RST_PLL_DHI 8'h00
`define CCP_RST_PLL_DLO 8'h00
`define CCP_RST_DIV 8'h01
`define CCP_RST_DAC_OVERSAMPLE_RATIO_HI 8'h00
`define CCP_RST_DAC_OVERSAMPLE_RATIO_LO 8'h80
`define CCP_RST_ADC_OVERSAMPLE_RATIO 8'h80
`define CCP_RST_ZERO 8'h00

// root source codes
`define CCP_SRC_MCLK 2'h0
`define CCP_SRC_BCLK 2'h1
`define CCP_SRC_GP1 2'h2
`define CCP_SRC_PLL 2'h3

// counts
`define CCP_PLL_FRAC_SCALE 20'h02710
`define CCP_SHUTDOWN_TICKS 8'h40

`endif

// ===== ccp_testbench.sv
// self-checking testbench for the codec clock tree
`timescale 1ns/1ns
`default_nettype none
`include "ccp_defs.vh"
module testbench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic mclk = 1'b0;
  logic bclk = 1'b0;
  logic gp1 = 1'b0;
  logic [3:0] src_cnt = 4'h0;
  wire [31:0] prdata;
  wire pready, pslverr, bclk_o, bclk_oe, gp1_o, gp1_oe, gp2_oe, sd_oe, mi_oe;
  wire gp2_o, sd_o, mi_o;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;

  ccp_clock_tree #(.SHUTDOWN_TICKS(4)) u_dut (.sys_clk_in(sys_clk),
    .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .mclk_in(mclk), .bclk_in(bclk), .gp1_in(gp1), .bclk_out(bclk_o),
    .bclk_oe_out(bclk_oe), .gp1_out(gp1_o), .gp1_oe_out(gp1_oe),
    .gp2_out(gp2_o), .gp2_oe_out(gp2_oe), .serial_data_out_pin_out(sd_o),
    .serial_data_out_pin_oe_out(sd_oe), .miso_out(mi_o), .miso_oe_out(mi_oe));

  // clock
  always #20 sys_clk = ~sys_clk;
  // source pins at periods of 4, 8 and 16 cycles
  always @(posedge sys_clk) begin
    src_cnt <= src_cnt + 4'h1;
    mclk <= src_cnt[1];
    bclk <= src_cnt[2];
    gp1 <= src_cnt[3];
  end
  // hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // edge counts may shift by one with the source phase
  task chk_count(input string what, input int exp, input int got);
    n_compared++;
    if (got < exp - 1 || got > exp + 1) begin
      err_count++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task do_reset;
    rst_n <= 1'b0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [7:0] d,
           output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    // this wait ends when pready rises, or else at the hang guard
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, {idx, 2'h0}, d, rd, err);
  endtask

  task rdchk(input string what, input logic [5:0] idx, input logic [7:0] m,
             input logic [7:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, {idx, 2'h0}, 8'h00, rd, err);
    chk(what, {24'h0, exp}, rd & {24'h0, m});
  endtask

  task count_rises(input logic use_gp, output int n);
    logic prev;
    logic cur;
    n = 0;
    prev = 1'b0;
    repeat (128) begin
      @(posedge sys_clk);
      cur = use_gp ? gp1_o : bclk_o;
      if (cur === 1'b1 && prev === 1'b0) n++;
      prev = cur;
    end
  endtask

  task t_reset_values;
    logic [7:0] t [17][2] = '{'{8'h04, 8'h00}, '{8'h05, 8'h11},
      '{8'h06, 8'h04}, '{8'h07, 8'h00}, '{8'h08, 8'h00}, '{8'h0B, 8'h01},
      '{8'h0C, 8'h01}, '{8'h0D, 8'h00}, '{8'h0E, 8'h80}, '{8'h12, 8'h01},
      '{8'h13, 8'h01}, '{8'h14, 8'h80}, '{8'h19, 8'h00}, '{8'h1A, 8'h01},
      '{8'h1D, 8'h00}, '{8'h1E, 8'h01}, '{8'h1B, 8'h00}};
    for (int i = 0; i < 17; i++)
      rdchk("reset value", t[i][0][5:0], 8'hFF, t[i][1]);
    chk("bit clock enable", 32'h0, {31'h0, bclk_oe});
    $display("test reset values done");
  endtask

  task t_readback;
    logic [7:0] t [9][2] = '{'{8'h05, 8'h9A}, '{8'h04, 8'h03},
      '{8'h06, 8'h3F}, '{8'h0D, 8'h03}, '{8'h0E, 8'hFF}, '{8'h14, 8'hFF},
      '{8'h19, 8'h07}, '{8'h1D, 8'h03}, '{8'h1E, 8'h7F}};
    logic [31:0] rd;
    logic err;
    for (int i = 0; i < 9; i++) wr(t[i][0][5:0], t[i][1]);
    for (int i = 0; i < 9; i++)
      rdchk("readback", t[i][0][5:0], 8'hFF, t[i][1]);
    apb(1'b0, 8'hFC, 8'h00, rd, err);
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(1'b1, 8'h11, 8'h55, rd, err);
    chk("misaligned error", 32'h1, {31'h0, err});
    wr(`CCP_IDX_ADC_FLAGS, 8'hFF);
    rdchk("flag write ignored", `CCP_IDX_ADC_FLAGS, 8'hFF, 8'h00);
    $display("test readback done");
  endtask

  // root, dac pre, dac mod, adc pre, adc mod, bit source, ratio, rises
  task t_bit_clock;
    logic [7:0] t [9][8] = '{
      '{8'h00, 8'h81, 8'h81, 8'h01, 8'h01, 8'h01, 8'h01, 8'h20},
      '{8'h01, 8'h81, 8'h81, 8'h01, 8'h01, 8'h01, 8'h01, 8'h10},
      '{8'h02, 8'h81, 8'h81, 8'h01, 8'h01, 8'h01, 8'h01, 8'h08},
      '{8'h00, 8'h82, 8'h81, 8'h01, 8'h01, 8'h00, 8'h01, 8'h10},
      '{8'h00, 8'h81, 8'h82, 8'h01, 8'h01, 8'h01, 8'h01, 8'h10},
      '{8'h00, 8'h81, 8'h81, 8'h01, 8'h01, 8'h01, 8'h04, 8'h08},
      '{8'h00, 8'h01, 8'h81, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00},
      '{8'h00, 8'h81, 8'h81, 8'h01, 8'h01, 8'h02, 8'h01, 8'h20},
      '{8'h00, 8'h81, 8'h81, 8'h82, 8'h81, 8'h03, 8'h01, 8'h10}};
    int n;
    for (int i = 0; i < 9; i++) begin
      do_reset();
      wr(`CCP_IDX_ROOT_SEL, t[i][0]);
      wr(`CCP_IDX_DAC_PRE, t[i][1]);
      wr(`CCP_IDX_DAC_MOD, t[i][2]);
      wr(`CCP_IDX_ADC_PRE, t[i][3]);
      wr(`CCP_IDX_ADC_MOD, t[i][4]);
      wr(`CCP_IDX_BCLK_SEL, t[i][5]);
      wr(`CCP_IDX_BCLK_DIV, 8'h80 | t[i][6]);
      wr(`CCP_IDX_BCLK_CTRL, 8'h08);
      count_rises(1'b0, n);
      chk_count("bit clock rises", int'(t[i][7]),
        n);
      chk("bit clock enable", 32'h1, {31'h0, bclk_oe});
    end
    $display("test bit clock done");
  endtask

  task gen_setup(input logic [7:0] epr, input logic [7:0] src,
                 input logic [7:0] div);
    do_reset();
    wr(`CCP_IDX_ROOT_SEL, 8'h08);
    wr(`CCP_IDX_DAC_PRE, 8'h81);
    wr(`CCP_IDX_DAC_MOD, 8'h81);
    wr(`CCP_IDX_PLL_EPR, epr);
    wr(`CCP_IDX_PLL_J, 8'h04);
    wr(`CCP_IDX_DAC_OVERSAMPLE_RATIO_LO, 8'h04);
    wr(`CCP_IDX_ADC_OVERSAMPLE_RATIO, 8'h04);
    wr(`CCP_IDX_GCLK_SEL, src);
    wr(`CCP_IDX_GCLK_DIV, div);
    wr(`CCP_IDX_GCLK_ROUTE, 8'h01);
    repeat (16) @(posedge sys_clk);
  endtask

  // pll control, general source, divider, rises
  task t_gen_clock;
    logic [7:0] t [8][4] = '{'{8'h91, 8'h01, 8'h82, 8'h10},
      '{8'h92, 8'h01, 8'h82, 8'h20}, '{8'hA1, 8'h01, 8'h82, 8'h08},
      '{8'h11, 8'h01, 8'h82, 8'h00}, '{8'h91, 8'h06, 8'h81, 8'h08},
      '{8'h91, 8'h07, 8'h81, 8'h08}, '{8'h91, 8'h00, 8'h81, 8'h20},
      '{8'h91, 8'h03, 8'h81, 8'h20}};
    int n;
    logic [3:0] seen;
    for (int i = 0; i < 8; i++) begin
      gen_setup(t[i][0], t[i][1], t[i][2]);
      count_rises(1'b1, n);
      chk_count("general clock rises", int'(t[i][3]),
        n);
    end
    // each route bit drives its own pin and no other
    for (int i = 0; i < 4; i++) begin
      wr(`CCP_IDX_GCLK_ROUTE, 8'h01 << i);
      seen = 4'h0;
      repeat (8) begin
        @(posedge sys_clk);
        seen = seen | {mi_o, sd_o, gp2_o, gp1_o};
      end
      chk("route enables", 32'h1 << i,
        {28'h0, mi_oe, sd_oe, gp2_oe, gp1_oe});
      chk("route pins", 32'h1 << i, {28'h0, seen});
    end
    gen_setup(8'h91, 8'h01, 8'h82);
    wr(`CCP_IDX_PLL_DHI, 8'h27);
    count_rises(1'b1, n);
    chk_count("fraction held", 16, n);
    wr(`CCP_IDX_PLL_DLO, 8'h0F);
    count_rises(1'b1, n);
    chk_count("fraction applied", 20, n);
    $display("test general clock done");
  endtask

  task t_power;
    do_reset();
    wr(`CCP_IDX_DAC_PRE, 8'h81);
    wr(`CCP_IDX_DAC_MOD, 8'h81);
    wr(`CCP_IDX_ADC_PRE, 8'h81);
    wr(`CCP_IDX_ADC_MOD, 8'h81);
    wr(`CCP_IDX_CHAN_POWER, 8'hE0);
    rdchk("dac flags on", `CCP_IDX_DAC_FLAGS, 8'h88, 8'h88);
    rdchk("adc flag on", `CCP_IDX_ADC_FLAGS, 8'h40, 8'h40);
    wr(`CCP_IDX_CHAN_POWER, 8'h00);
    wr(`CCP_IDX_DAC_MOD, 8'h01);
    repeat (64) @(posedge sys_clk);
    rdchk("dac flags stalled", `CCP_IDX_DAC_FLAGS, 8'h88,
      8'h88);
    rdchk("adc flag off", `CCP_IDX_ADC_FLAGS, 8'h40, 8'h00);
    wr(`CCP_IDX_DAC_MOD, 8'h81);
    repeat (64) @(posedge sys_clk);
    rdchk("dac flags off", `CCP_IDX_DAC_FLAGS, 8'h88, 8'h00);
    // children before parents, dac dividers last
    wr(`CCP_IDX_ADC_MOD, 8'h01);
    wr(`CCP_IDX_ADC_PRE, 8'h01);
    wr(`CCP_IDX_DAC_MOD, 8'h01);
    wr(`CCP_IDX_DAC_PRE, 8'h01);
    $display("test power down done");
  endtask

  // main sequence
  initial begin
    do_reset();
    t_reset_values();
    t_readback();
    t_bit_clock();
    t_gen_clock();
    t_power();
    report_and_stop();
  end
endmodule

bind ccp_clock_tree ccp_properties u_props (.sys_clk_in(sys_clk_in),
  .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out),
  .bclk_oe_out(bclk_oe_out), .gp1_oe_out(gp1_oe_out),
  .gp2_oe_out(gp2_oe_out), .serial_data_out_pin_oe_out(serial_data_out_pin_oe_out),
  .miso_oe_out(miso_oe_out));
`default_nettype wire
